// [hw/plbst_top.sv]
`timescale 1ns/10ps
`default_nettype none
// small fifo; ready and valid come from flops
module plbst_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];      // storage
	logic [AW-1:0]    wr_ptr_ff;        // write slot
	logic [AW-1:0]    rd_ptr_ff;        // read slot
	logic [AW:0]      count_ff;         // occupancy
	logic [AW:0]      nxt_count;
	logic             in_ready_ff;
	logic             out_valid_ff;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready_ff;
	assign pop       = out_valid_ff && out_ready;
	assign in_ready  = in_ready_ff;
	assign out_valid = out_valid_ff;
	assign out_data  = mem[rd_ptr_ff];

	// occupancy drives both flags so they never disagree
	always_comb begin
		nxt_count = count_ff;
		if (push && !pop) nxt_count = count_ff + 1'b1;
		else if (pop && !push) nxt_count = count_ff - 1'b1;
	end

	// pointers and flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff    <= '0;
			rd_ptr_ff    <= '0;
			count_ff     <= '0;
			in_ready_ff  <= 1'b1;
			out_valid_ff <= 1'b0;
		end else if (ce) begin
			if (push) wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
			if (pop) rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
			count_ff     <= nxt_count;
			in_ready_ff  <= (nxt_count != FULL);
			out_valid_ff <= (nxt_count != '0);
		end
	end

	// data array, no reset needed
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end
endmodule

// loopback selection and prbs self test
module plbst_top #(
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	output logic             reg_rvalid,
	input  wire logic [2:0]  op_mode,
	input  wire logic [1:0]  link_speed,
	input  wire logic [7:0]  mac_tx_data,
	input  wire logic        mac_tx_valid,
	output logic             mac_tx_ready,
	output logic [7:0]       mac_rx_data,
	output logic             mac_rx_valid,
	output logic [7:0]       line_tx_data,
	output logic             line_tx_valid,
	input  wire logic        line_tx_ready,
	input  wire logic [7:0]  line_rx_data,
	input  wire logic        line_rx_valid
);
	// reset release
	logic rst_meta_ff;
	logic rst_n_ff;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// line receive pins cross in through two stages
	logic [7:0] rx_meta_data_ff;
	logic       rx_meta_vld_ff;
	logic [7:0] rx_data_ff;
	logic       rx_vld_ff;
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rx_meta_data_ff <= 8'h00;
			rx_meta_vld_ff  <= 1'b0;
			rx_data_ff      <= 8'h00;
			rx_vld_ff       <= 1'b0;
		end else if (clk_en) begin
			rx_meta_data_ff <= line_rx_data;
			rx_meta_vld_ff  <= line_rx_valid;
			rx_data_ff      <= rx_meta_data_ff;
			rx_vld_ff       <= rx_meta_vld_ff;
		end
	end

	// management registers
	logic [15:0] bmc_ff;        // basic_mode_control
	logic [15:0] stc_ff;        // selftest_control
	logic [15:0] loopset_ff;    // loopback_setup, held for software
	logic [15:0] pkt_len_ff;    // bytes per packet
	logic [15:0] gap_len_ff;    // idle cycles between packets
	logic        wr_hit;
	logic        chk_clr;
	assign wr_hit  = reg_wr && clk_en;
	assign chk_clr = wr_hit && reg_addr == plbst_pkg::ADDR_CHECKER_ERRORS && reg_wdata[plbst_pkg::CHK_CLR_BIT];

	// writes to read-only offsets are dropped
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			bmc_ff     <= plbst_pkg::RST_BMC;
			stc_ff     <= plbst_pkg::RST_STC;
			loopset_ff <= plbst_pkg::RST_LOOPSET;
			pkt_len_ff <= plbst_pkg::RST_PKT_LEN;
			gap_len_ff <= plbst_pkg::RST_GAP_LEN;
		end else if (wr_hit) begin
			if (reg_addr == plbst_pkg::ADDR_BASIC_MODE_CONTROL) bmc_ff <= reg_wdata;
			else if (reg_addr == plbst_pkg::ADDR_SELFTEST_CONTROL) stc_ff <= reg_wdata;
			else if (reg_addr == plbst_pkg::ADDR_LOOPBACK_SETUP) loopset_ff <= reg_wdata;
			else if (reg_addr == plbst_pkg::ADDR_PKT_LENGTH) pkt_len_ff <= reg_wdata;
			else if (reg_addr == plbst_pkg::ADDR_GAP_LENGTH) gap_len_ff <= reg_wdata;
		end
	end

	// decoded controls
	logic gen_en;
	logic chk_en;
	logic cont_mode;
	logic rev_to_mac;
	logic mii_media;
	assign gen_en     = stc_ff[plbst_pkg::STC_GEN_BIT];
	assign chk_en     = stc_ff[plbst_pkg::STC_CHK_BIT];
	assign cont_mode  = stc_ff[plbst_pkg::STC_CONT_BIT];
	assign rev_to_mac = stc_ff[plbst_pkg::STC_REVMAC_BIT];
	assign mii_media  = stc_ff[plbst_pkg::STC_MEDIA_BIT];

	// requested loop; the control register bit beats the field
	plbst_pkg::plbst_lb_e lb_req;
	always_comb begin
		lb_req = plbst_pkg::LB_NONE;
		if (bmc_ff[plbst_pkg::BMC_LOOP_BIT]) lb_req = plbst_pkg::LB_MII;
		else if (stc_ff[plbst_pkg::STC_LB_LSB+:3] <= 3'h5) lb_req = plbst_pkg::plbst_lb_e'(stc_ff[plbst_pkg::STC_LB_LSB+:3]);
	end

	// loop in force, registered so mode changes apply on a clean edge
	plbst_pkg::plbst_lb_e lb_ff;
	logic                 refused_ff;  // request not available here
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			lb_ff      <= plbst_pkg::LB_NONE;
			refused_ff <= 1'b0;
		end else if (clk_en) begin
			if (plbst_pkg::lb_allowed(op_mode, link_speed, lb_req)) begin
				lb_ff      <= lb_req;
				refused_ff <= 1'b0;
			end else begin
				lb_ff      <= plbst_pkg::LB_NONE;
				refused_ff <= 1'b1;
			end
		end
	end

	logic internal;  // data turns inside the device
	logic to_line;   // drained bytes go out on the line
	logic rev;
	assign internal = lb_ff == plbst_pkg::LB_MII || lb_ff == plbst_pkg::LB_PCS
		|| lb_ff == plbst_pkg::LB_DIG || lb_ff == plbst_pkg::LB_ANA;
	assign to_line  = !internal || (lb_ff == plbst_pkg::LB_MII && mii_media);
	assign rev      = lb_ff == plbst_pkg::LB_REV;

	// prbs generator
	plbst_pkg::plbst_gen_e gen_st_ff;
	logic [14:0]           gen_lfsr_ff;
	logic [15:0]           gen_cnt_ff;
	logic [7:0]            gen_byte;
	logic [14:0]           gen_next;
	logic                  gen_push;
	logic                  fifo_in_ready;
	assign gen_next = plbst_pkg::prbs_next(gen_lfsr_ff);
	assign gen_byte = gen_next[7:0];
	assign gen_push = gen_st_ff == plbst_pkg::GEN_PKT && fifo_in_ready && !rev;

	// packet then gap; a started packet always completes
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			gen_st_ff   <= plbst_pkg::GEN_IDLE;
			gen_lfsr_ff <= plbst_pkg::PRBS_SEED;
			gen_cnt_ff  <= 16'h0000;
		end else if (clk_en) begin
			case (gen_st_ff)
				plbst_pkg::GEN_IDLE: begin
					gen_cnt_ff <= 16'h0000;
					if (gen_en && !rev) gen_st_ff <= plbst_pkg::GEN_PKT;
				end
				plbst_pkg::GEN_PKT: begin
					if (gen_push) begin
						gen_lfsr_ff <= gen_next;
						gen_cnt_ff  <= gen_cnt_ff + 16'h0001;
						if (gen_cnt_ff + 16'h0001 >= pkt_len_ff) begin
							gen_cnt_ff <= 16'h0000;
							gen_st_ff  <= plbst_pkg::GEN_GAP;
						end
					end
				end
				plbst_pkg::GEN_GAP: begin
					gen_cnt_ff <= gen_cnt_ff + 16'h0001;
					if (gen_cnt_ff + 16'h0001 >= gen_len_ok(gap_len_ff)) begin
						gen_cnt_ff <= 16'h0000;
						gen_st_ff  <= gen_en ? plbst_pkg::GEN_PKT : plbst_pkg::GEN_IDLE;
					end
				end
				default: gen_st_ff <= plbst_pkg::GEN_IDLE;
			endcase
		end
	end

	// a gap of zero still costs one idle cycle
	function automatic logic [15:0] gen_len_ok(input logic [15:0] n);
		return (n == 16'h0000) ? 16'h0001 : n;
	endfunction

	// transmit source: reverse loop ignores the mac, else prbs or mac
	logic [7:0] fifo_in_data;
	logic       fifo_in_valid;
	always_comb begin
		fifo_in_data  = mac_tx_data;
		fifo_in_valid = mac_tx_valid && !gen_en;
		if (rev) begin
			fifo_in_data  = rx_data_ff;
			fifo_in_valid = rx_vld_ff;
		end else if (gen_en || gen_st_ff != plbst_pkg::GEN_IDLE) begin
			fifo_in_data  = gen_byte;
			fifo_in_valid = gen_push;
		end
	end

	logic [7:0] fifo_out_data;
	logic       fifo_out_valid;
	logic       fifo_out_ready;
	logic       line_vld_ff;
	logic [7:0] line_data_ff;
	assign fifo_out_ready = to_line ? (!line_vld_ff || line_tx_ready) : 1'b1;

	// mac data stalls here when the line holds off
	plbst_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_txq (
		.clk       (core_clk),
		.rst_n     (rst_n_ff),
		.ce        (clk_en),
		.in_data   (fifo_in_data),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready)
	);
	assign mac_tx_ready = fifo_in_ready;

	logic pop;
	assign pop = fifo_out_valid && fifo_out_ready;

	// line transmit stage holds a byte until the line takes it
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			line_vld_ff  <= 1'b0;
			line_data_ff <= 8'h00;
		end else if (clk_en) begin
			if (pop && to_line) begin
				line_vld_ff  <= 1'b1;
				line_data_ff <= fifo_out_data;
			end else if (line_tx_ready) begin
				line_vld_ff <= 1'b0;
			end
		end
	end
	assign line_tx_valid = line_vld_ff;
	assign line_tx_data  = line_data_ff;

	// internal loop pipe; deeper loop points return later
	logic [7:0] dly_data_ff [4];
	logic [3:0] dly_vld_ff;
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			dly_vld_ff <= 4'h0;
			for (int i = 0; i < 4; i++) dly_data_ff[i] <= 8'h00;
		end else if (clk_en) begin
			dly_vld_ff     <= {dly_vld_ff[2:0], pop && internal};
			dly_data_ff[0] <= fifo_out_data;
			for (int i = 1; i < 4; i++) dly_data_ff[i] <= dly_data_ff[i-1];
		end
	end

	// receive byte toward the mac and the checker
	logic [7:0] rxb_data;
	logic       rxb_vld;
	always_comb begin
		rxb_data = rx_data_ff;
		rxb_vld  = rx_vld_ff;
		case (lb_ff)
			plbst_pkg::LB_MII: begin
				rxb_data = dly_data_ff[0];
				rxb_vld  = dly_vld_ff[0];
			end
			plbst_pkg::LB_PCS: begin
				rxb_data = dly_data_ff[1];
				rxb_vld  = dly_vld_ff[1];
			end
			plbst_pkg::LB_DIG: begin
				rxb_data = dly_data_ff[2];
				rxb_vld  = dly_vld_ff[2];
			end
			plbst_pkg::LB_ANA: begin
				rxb_data = dly_data_ff[3];
				rxb_vld  = dly_vld_ff[3];
			end
			plbst_pkg::LB_REV: rxb_vld = rx_vld_ff && rev_to_mac;
			default: rxb_vld = rx_vld_ff;  // external and none use the line
		endcase
	end

	// mac receive output
	logic [7:0] mac_data_ff;
	logic       mac_vld_ff;
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			mac_data_ff <= 8'h00;
			mac_vld_ff  <= 1'b0;
		end else if (clk_en) begin
			mac_data_ff <= rxb_data;
			mac_vld_ff  <= rxb_vld;
		end
	end
	assign mac_rx_data  = mac_data_ff;
	assign mac_rx_valid = mac_vld_ff;

	// checker sees every received byte, also reverse-only ones
	logic        chk_vld;
	logic [14:0] hist_ff;    // last fifteen received bits
	logic [2:0]  run_ff;     // consecutive match or miss count
	logic        lock_ff;
	logic        lost_ff;
	logic [7:0]  err_ff;
	logic [15:0] bytes_ff;
	logic        match;
	logic [14:0] hist_pred;  // history stepped one byte ahead
	logic [15:0] err_base;
	logic [15:0] bytes_base;
	logic [15:0] err_inc;
	assign chk_vld    = chk_en && (rev ? rx_vld_ff : rxb_vld);
	assign hist_pred  = plbst_pkg::prbs_next(hist_ff);
	assign match      = rxb_data == hist_pred[7:0];
	assign err_base   = chk_clr ? 16'h0000 : {8'h00, err_ff};
	assign bytes_base = chk_clr ? 16'h0000 : bytes_ff;
	assign err_inc    = plbst_pkg::cnt_step(err_base, {8'h00, plbst_pkg::ERR_MAX}, cont_mode);

	// self-synchronising check; a new event beats a clear
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			hist_ff  <= 15'h0000;
			run_ff   <= 3'h0;
			lock_ff  <= 1'b0;
			lost_ff  <= 1'b0;
			err_ff   <= 8'h00;
			bytes_ff <= 16'h0000;
		end else if (clk_en) begin
			err_ff   <= err_base[7:0];
			bytes_ff <= bytes_base;
			lost_ff  <= lost_ff && !chk_clr;
			if (!chk_en) begin
				lock_ff <= 1'b0;
				run_ff  <= 3'h0;
			end else if (chk_vld) begin
				hist_ff  <= {hist_ff[6:0], rxb_data};
				bytes_ff <= plbst_pkg::cnt_step(bytes_base, 16'hffff, cont_mode);
				if (!lock_ff) begin
					run_ff <= match ? run_ff + 3'h1 : 3'h0;
					if (match && run_ff + 3'h1 >= plbst_pkg::LOCK_RUN) begin
						lock_ff <= 1'b1;
						run_ff  <= 3'h0;
					end
				end else if (!match) begin
					err_ff <= err_inc[7:0];
					run_ff <= run_ff + 3'h1;
					if (run_ff + 3'h1 >= plbst_pkg::LOSS_RUN) begin
						lock_ff <= 1'b0;
						lost_ff <= 1'b1;
						run_ff  <= 3'h0;
					end
				end else begin
					run_ff <= 3'h0;
				end
			end
		end
	end

	// register read, answered one edge later
	logic [15:0] rdata_ff;
	logic        rvalid_ff;
	logic        busy;
	assign busy = gen_st_ff != plbst_pkg::GEN_IDLE;
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rdata_ff  <= 16'h0000;
			rvalid_ff <= 1'b0;
		end else if (clk_en) begin
			rvalid_ff <= reg_rd;
			if (!reg_rd) rdata_ff <= rdata_ff;
			else if (reg_addr == plbst_pkg::ADDR_BASIC_MODE_CONTROL) rdata_ff <= bmc_ff;
			else if (reg_addr == plbst_pkg::ADDR_SELFTEST_CONTROL) rdata_ff <= stc_ff;
			else if (reg_addr == plbst_pkg::ADDR_SELFTEST_STATUS)
				rdata_ff <= {11'h000, refused_ff, lb_ff != plbst_pkg::LB_NONE, busy, lost_ff, lock_ff};
			else if (reg_addr == plbst_pkg::ADDR_CHECKER_ERRORS) rdata_ff <= {8'h00, err_ff};
			else if (reg_addr == plbst_pkg::ADDR_RX_BYTE_COUNT) rdata_ff <= bytes_ff;
			else if (reg_addr == plbst_pkg::ADDR_PKT_LENGTH) rdata_ff <= pkt_len_ff;
			else if (reg_addr == plbst_pkg::ADDR_GAP_LENGTH) rdata_ff <= gap_len_ff;
			else if (reg_addr == plbst_pkg::ADDR_LOOPBACK_SETUP) rdata_ff <= loopset_ff;
			else rdata_ff <= 16'h0000;
		end
	end
	assign reg_rdata  = rdata_ff;
	assign reg_rvalid = rvalid_ff;
endmodule
`default_nettype wire

// [hw/plbst_pkg.sv]
`default_nettype none
package plbst_pkg;
	// register offsets
	localparam logic [7:0] ADDR_BASIC_MODE_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_SELFTEST_CONTROL   = 8'h16;
	localparam logic [7:0] ADDR_SELFTEST_STATUS    = 8'h17;
	localparam logic [7:0] ADDR_CHECKER_ERRORS     = 8'h39;
	localparam logic [7:0] ADDR_RX_BYTE_COUNT      = 8'h3a;
	localparam logic [7:0] ADDR_PKT_LENGTH         = 8'h3b;
	localparam logic [7:0] ADDR_GAP_LENGTH         = 8'h3c;
	localparam logic [7:0] ADDR_LOOPBACK_SETUP     = 8'hfe;
	// field positions
	localparam int BMC_LOOP_BIT   = 14;
	localparam int STC_REVMAC_BIT = 4;
	localparam int STC_MEDIA_BIT  = 5;
	localparam int STC_LB_LSB     = 8;
	localparam int STC_GEN_BIT    = 12;
	localparam int STC_CHK_BIT    = 13;
	localparam int STC_CONT_BIT   = 14;
	localparam int CHK_CLR_BIT    = 8;
	// values after reset
	localparam logic [15:0] RST_BMC     = 16'h0000;
	localparam logic [15:0] RST_STC     = 16'h0000;
	localparam logic [15:0] RST_LOOPSET = 16'h0000;
	localparam logic [15:0] RST_PKT_LEN = 16'h0040;
	localparam logic [15:0] RST_GAP_LEN = 16'h000c;
	localparam logic [14:0] PRBS_SEED   = 15'h7fff;
	// checker run lengths
	localparam logic [2:0] LOCK_RUN = 3'h4;
	localparam logic [2:0] LOSS_RUN = 3'h4;
	localparam logic [7:0] ERR_MAX  = 8'hff;
	// operating modes and speeds
	localparam logic [2:0] OP_COPPER = 3'h0;
	localparam logic [2:0] OP_FIBER  = 3'h1;
	localparam logic [2:0] OP_S2R    = 3'h2;
	localparam logic [2:0] OP_R2S    = 3'h3;
	localparam logic [2:0] OP_MCONV  = 3'h4;
	localparam logic [1:0] SPD_10    = 2'h0;
	localparam logic [1:0] SPD_100   = 2'h1;
	localparam logic [1:0] SPD_1000  = 2'h2;

	typedef enum logic [2:0] {LB_NONE, LB_PCS, LB_DIG, LB_ANA, LB_EXT, LB_REV, LB_MII} plbst_lb_e;
	typedef enum logic [1:0] {GEN_IDLE, GEN_PKT, GEN_GAP} plbst_gen_e;

	// eight shifts of x^15+x^14+1; the low byte holds the new bits
	function automatic logic [14:0] prbs_next(input logic [14:0] s);
		logic [14:0] t;
		t = s;
		for (int i = 0; i < 8; i++) begin
			t = {t[13:0], t[14] ^ t[13]};
		end
		return t;
	endfunction

	// counter step: wrap in continuous mode, else stick at max
	function automatic logic [15:0] cnt_step(input logic [15:0] v, input logic [15:0] max, input logic wrap);
		logic [15:0] r;
		r = v + 16'h0001;
		if (v == max) begin
			r = wrap ? 16'h0000 : max;
		end
		return r;
	endfunction

	// loop availability per medium, bridge and speed
	function automatic logic lb_allowed(input logic [2:0] op, input logic [1:0] spd, input plbst_lb_e lb);
		logic ok;
		ok = 1'b1;
		if (op == OP_COPPER) begin
			if ((lb == LB_PCS && spd == SPD_10) || (lb == LB_MII && spd == SPD_100)) ok = 1'b0;
			if (lb == LB_EXT && spd == SPD_1000) ok = 1'b0;
		end else if (op == OP_FIBER) begin
			if (lb == LB_PCS && spd == SPD_100) ok = 1'b0;
			if (lb == LB_ANA && spd != SPD_10) ok = 1'b0;
			if (lb == LB_EXT) ok = 1'b0;
		end else if (op == OP_S2R) begin
			if (lb == LB_PCS || lb == LB_DIG || lb == LB_ANA || lb == LB_EXT) ok = 1'b0;
		end else if (op == OP_R2S) begin
			if (lb == LB_PCS || lb == LB_EXT) ok = 1'b0;
		end else if (op == OP_MCONV) begin
			if ((lb == LB_MII || lb == LB_EXT) && spd != SPD_10) ok = 1'b0;
			if (lb == LB_ANA && spd == SPD_100) ok = 1'b0;
		end
		return ok;
	endfunction
endpackage
`default_nettype wire

// [verification/plbst_top_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// register mirrors and handshake checks at the top ports
module plbst_top_properties (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        clk_en,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic [7:0]  line_tx_data,
	input wire logic        line_tx_valid,
	input wire logic        line_tx_ready,
	input wire logic        mac_tx_ready,
	input wire logic        mac_rx_valid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic [15:0] m_ff [5]; // stored registers as written
	logic        rd_ok;    // read with no write beside it
	assign rd_ok = clk_en && reg_rd && !reg_wr;
	// mirror of plain stored registers
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			m_ff <= '{plbst_pkg::RST_BMC, plbst_pkg::RST_STC, plbst_pkg::RST_LOOPSET,
				plbst_pkg::RST_PKT_LEN, plbst_pkg::RST_GAP_LEN};
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				8'h00: m_ff[0] <= reg_wdata;
				8'h16: m_ff[1] <= reg_wdata;
				8'hfe: m_ff[2] <= reg_wdata;
				8'h3b: m_ff[3] <= reg_wdata;
				8'h3c: m_ff[4] <= reg_wdata;
				default: ;
			endcase
		end
	end
	// read of address a returns the mirror one edge later
	property p_back(a, v);
		rd_ok && reg_addr == a |=> reg_rdata == v;
	endproperty
	chk_mode_readback: assert property (p_back(8'h00, m_ff[0]))
		else $error("mode control readback wrong");
	chk_selftest_readback: assert property (p_back(8'h16, m_ff[1]))
		else $error("selftest control readback wrong");
	chk_setup_readback: assert property (p_back(8'hfe, m_ff[2]))
		else $error("loopback setup readback wrong");
	chk_pkt_readback: assert property (p_back(8'h3b, m_ff[3]))
		else $error("packet length readback wrong");
	chk_gap_readback: assert property (p_back(8'h3c, m_ff[4]))
		else $error("gap length readback wrong");
	chk_unmapped_zero: assert property (rd_ok && !(reg_addr inside {8'h00, 8'h16, 8'h17, 8'h39,
		8'h3a, 8'h3b, 8'h3c, 8'hfe}) |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
	chk_read_answer: assert property (clk_en && reg_rd |=> reg_rvalid)
		else $error("read not answered");
	chk_rvalid_cause: assert property (reg_rvalid |-> $past(clk_en) && $past(reg_rd))
		else $error("read valid without read");
	chk_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
		else $error("read data moved between reads");
	chk_line_hold: assert property (line_tx_valid && !line_tx_ready |=> line_tx_valid && $stable(line_tx_data))
		else $error("line byte dropped while stalled");
	cover property (reg_rvalid);
	cover property (line_tx_valid && line_tx_ready);
	cover property (mac_rx_valid);
	cover property (!mac_tx_ready);
endmodule
bind plbst_top plbst_top_properties u_plbst_top_properties (
	.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .line_tx_data(line_tx_data), .line_tx_valid(line_tx_valid),
	.line_tx_ready(line_tx_ready), .mac_tx_ready(mac_tx_ready), .mac_rx_valid(mac_rx_valid));
`default_nettype wire

// [verification/plbst_line_model.sv]
`timescale 1ns/10ps
`default_nettype none
// far end: cable fixture looping line tx into line rx
module plbst_line_model (
	input  wire logic       core_clk,
	input  wire logic       loop_en,
	input  wire logic       stall,
	input  wire logic       corrupt,
	input  wire logic [7:0] line_tx_data,
	input  wire logic       line_tx_valid,
	output logic            line_tx_ready,
	output logic [7:0]      line_rx_data,
	output logic            line_rx_valid
);
	initial begin
		line_tx_ready = 1'h0;
		line_rx_data = 8'h00;
		line_rx_valid = 1'h0;
	end
	// random back-pressure so the line stage must hold
	always @(posedge core_clk) begin
		line_tx_ready <= !stall && ($urandom_range(3) != 0);
		line_rx_valid <= loop_en && line_tx_valid && line_tx_ready;
		if (loop_en && line_tx_valid && line_tx_ready) begin
			line_rx_data <= line_tx_data ^ (corrupt ? 8'($urandom_range(255, 1)) : 8'h00);
		end else begin
			line_rx_data <= ~line_rx_data; // idle wire inverts the last value each cycle
		end
	end
endmodule
`default_nettype wire

// [verification/plbst_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module plbst_top_tb;
	logic        core_clk = 1'h0, reset_n = 1'h0, clk_en = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	logic        mac_tx_valid = 1'h0, loop_en = 1'h0, stall = 1'h0, corrupt = 1'h0;
	logic [2:0]  op_mode = 3'h0;
	logic [1:0]  link_speed = 2'h2;
	logic [7:0]  reg_addr = 8'h00, mac_tx_data = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, v, d;
	logic [15:0] reg_rdata;
	logic        reg_rvalid, mac_tx_ready, mac_rx_valid, line_tx_valid, line_tx_ready, line_rx_valid;
	logic [7:0]  mac_rx_data, line_tx_data, line_rx_data;
	logic [7:0]  sq[$], rxq[$], lq[$]; // sent, back at mac, on line
	logic [7:0]  ra [8] = '{8'h00, 8'h16, 8'hfe, 8'h3b, 8'h3c, 8'h17, 8'h3a, 8'h55};
	logic [15:0] rv [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0040, 16'h000c, 16'h0000, 16'h0000, 16'h0000};
	int          fail_count = 0, n_tests = 0;
	bit          ok;
	always #2.5 core_clk = ~core_clk;
	plbst_top u_plbst_top (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .op_mode(op_mode), .link_speed(link_speed), .mac_tx_data(mac_tx_data),
		.mac_tx_valid(mac_tx_valid), .mac_tx_ready(mac_tx_ready), .mac_rx_data(mac_rx_data),
		.mac_rx_valid(mac_rx_valid), .line_tx_data(line_tx_data), .line_tx_valid(line_tx_valid),
		.line_tx_ready(line_tx_ready), .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid));
	plbst_line_model u_plbst_line_model (.core_clk(core_clk), .loop_en(loop_en), .stall(stall),
		.corrupt(corrupt), .line_tx_data(line_tx_data), .line_tx_valid(line_tx_valid),
		.line_tx_ready(line_tx_ready), .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid));
	// collect bytes at both egress points
	always @(posedge core_clk) begin
		if (mac_rx_valid === 1'h1) rxq.push_back(mac_rx_data);
		if (line_tx_valid === 1'h1 && line_tx_ready === 1'h1) lq.push_back(line_tx_data);
	end
	// loop unavailable for medium o, speed s, loop l (6 = mii)
	function automatic bit na(int o, int s, int l);
		case (o)
			0: return (l == 1 && s == 0) || (l == 4 && s == 2) || (l == 6 && s == 1);
			1: return (l == 1 && s == 1) || (l == 3 && s > 0) || l == 4;
			2: return l > 0 && l < 5;
			3: return l == 1 || l == 4;
			default: return (l == 6 && s > 0) || (l == 4 && s > 0) || (l == 3 && s == 1);
		endcase
	endfunction
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] w);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = w;
		reg_wr = 1'h1;
		@(negedge core_clk);
		reg_wr = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'h1;
		@(negedge core_clk);
		reg_rd = 1'h0;
		v = reg_rdata;
		chk({15'h0000, reg_rvalid}, 16'h0001);
	endtask
	// hold the byte until ready, at most lim cycles
	task automatic send(input logic [7:0] b, input int lim);
		@(negedge core_clk);
		mac_tx_data = b;
		mac_tx_valid = 1'h1;
		for (int i = 0; i < lim && mac_tx_ready !== 1'h1; i++) @(negedge core_clk);
		ok = mac_tx_ready === 1'h1;
		if (ok) sq.push_back(b);
	endtask
	task automatic idle(input int n);
		@(negedge core_clk);
		mac_tx_valid = 1'h0;
		repeat (n) @(negedge core_clk);
	endtask
	task automatic cmpq(input logic [7:0] q[$]);
		chk(16'(q.size()), 16'(sq.size()));
		for (int i = 0; i < sq.size() && i < q.size(); i++) chk({8'h00, q[i]}, {8'h00, sq[i]});
	endtask
	initial begin
		void'($urandom(99323));
		repeat (12) @(negedge core_clk);
		reset_n = 1'h1;
		repeat (3) @(negedge core_clk);
		for (int i = 0; i < 8; i++) begin
			rd(ra[i]);
			chk(v, rv[i]);
		end
		$display("test 1 done");
		// random stored values; byte count refuses writes, as does a write with clk_en low
		repeat (6) begin
			d = 16'($urandom);
			wr(8'hfe, d);
			wr(8'h17, d);
			wr(8'h3a, d);
			clk_en = 1'h0;
			wr(8'hfe, ~d);
			clk_en = 1'h1;
			rd(8'hfe);
			chk(v, d);
			rd(8'h3a);
			chk(v, 16'h0000);
		end
		wr(8'hfe, 16'he720);
		$display("test 2 done");
		for (int o = 0; o < 5; o++) for (int s = 0; s < 3; s++) for (int l = 1; l < 7; l++) begin
			op_mode = 3'(o);
			link_speed = 2'(s);
			wr(8'h00, l == 6 ? 16'h4000 : 16'h0000);
			wr(8'h16, l == 6 ? 16'h0004 : 16'(l << 8));
			rd(8'h17);
			chk({14'h0000, v[4:3]}, {14'h0000, na(o, s, l), !na(o, s, l)});
		end
		$display("test 3 done");
		op_mode = 3'h0;
		link_speed = 2'h2;
		// mii, pcs, digital, analog, then mii also onto the line
		for (int m = 0; m < 5; m++) begin
			wr(8'h00, m == 0 || m == 4 ? 16'h4000 : 16'h0000);
			wr(8'h16, m == 0 ? 16'h0004 : m == 4 ? 16'h0024 : 16'(m << 8));
			idle(20);
			sq.delete();
			rxq.delete();
			lq.delete();
			repeat (12) send(8'($urandom), 50);
			idle(40);
			cmpq(rxq);
			if (m == 4) cmpq(lq);
		end
		$display("test 4 done");
		wr(8'h00, 16'h0000);
		wr(8'h16, 16'h0000);
		stall = 1'h1;
		idle(10);
		sq.delete();
		lq.delete();
		ok = 1'h1;
		for (int i = 0; i < 9 && ok; i++) send(8'($urandom), 3);
		chk({15'h0000, ok}, 16'h0000);
		stall = 1'h0;
		send(mac_tx_data, 50);
		idle(40);
		cmpq(lq);
		$display("test 5 done");
		loop_en = 1'h1;
		wr(8'h39, 16'h0100);
		wr(8'h16, 16'h3000);
		idle(400);
		rd(8'h17);
		chk({13'h0000, v[2:0]}, 16'h0005);
		rd(8'h39);
		chk({8'h00, v[7:0]}, 16'h0000);
		rd(8'h3a);
		chk({15'h0000, v != 16'h0000}, 16'h0001);
		corrupt = 1'h1;
		idle(60);
		corrupt = 1'h0;
		idle(400);
		rd(8'h17);
		chk({13'h0000, v[2:0]}, 16'h0007);
		rd(8'h39);
		chk({15'h0000, v[7:0] != 8'h00}, 16'h0001);
		wr(8'h39, 16'h0100);
		rd(8'h39);
		chk({8'h00, v[7:0]}, 16'h0000);
		$display("test 6 done");
		report_and_stop();
	end
	// a hang counts as a mismatch
	initial begin
		#400000;
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
